/* File: verilog/kwd_pkg.sv */
package kwd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 32;
    localparam logic [31:0] KEY14_CTRL_ADDR = 32'hffff_f36e;
    localparam logic [31:0] KEY15_CTRL_ADDR = 32'hffff_f36f;
    localparam logic [31:0] KEY16_CTRL_ADDR = 32'hffff_f370;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hffff_f3f0;
    localparam logic [31:0] IRQ_MASK_ADDR   = 32'hffff_f3f1;

    // ------------------------------------------------------------
    // Field layout of a channel control register
    // ------------------------------------------------------------
    localparam int unsigned PULLUP_BIT = 7;
    localparam int unsigned SEL_HI     = 6;
    localparam int unsigned SEL_LO     = 4;
    localparam int unsigned EN_BIT     = 0;

    localparam logic [2:0] SEL_LOW   = 3'h0;
    localparam logic [2:0] SEL_HIGH  = 3'h1;
    localparam logic [2:0] SEL_FALL  = 3'h2;
    localparam logic [2:0] SEL_RISE  = 3'h3;
    localparam logic [2:0] SEL_BOTH  = 3'h4;

    localparam logic PULLUP_STATIC  = 1'b0;
    localparam logic PULLUP_DYNAMIC = 1'b1;

    typedef struct packed {
        logic       pullup_mode;
        logic [2:0] active_sel;
        logic       irq_enable;
    } kwd_chan_cfg_t;

    localparam kwd_chan_cfg_t CHAN_RESET = '{
        pullup_mode: PULLUP_STATIC,
        active_sel:  SEL_FALL,
        irq_enable:  1'b0
    };

endpackage : kwd_pkg

/* File: verilog/kwd_key_wakeup.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module kwd_key_wakeup #(
    parameter int unsigned NCH = 3
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic [31:0]       addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    input  wire logic [NCH-1:0]    key_i,
    output logic      [NCH-1:0]    pullup_dyn_o,
    output logic                   irq_o
);

    // ------------------------------------------------------------
    // Channel configuration
    // ------------------------------------------------------------
    kwd_pkg::kwd_chan_cfg_t [NCH-1:0] cfg_q, cfg_d;
    logic [NCH-1:0] sync1_q, sync2_q, prev_q;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [NCH-1:0] ch_wr;
    logic [7:0]     rdata_q, rdata_d;

    function automatic logic [31:0] ch_addr(input int unsigned n);
        unique case (n)
            0:       ch_addr = kwd_pkg::KEY14_CTRL_ADDR;
            1:       ch_addr = kwd_pkg::KEY15_CTRL_ADDR;
            default: ch_addr = kwd_pkg::KEY16_CTRL_ADDR;
        endcase
    endfunction : ch_addr

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign ch_wr[g] = wr_i && (addr_i == ch_addr(g));
            // Level modes fire every cycle the level holds; sticky
            // status then stays set until written one-to-clear after the level goes away.
            always_comb begin
                unique case (cfg_q[g].active_sel)
                    kwd_pkg::SEL_LOW:  hit[g] = !sync2_q[g];
                    kwd_pkg::SEL_HIGH: hit[g] = sync2_q[g];
                    kwd_pkg::SEL_FALL: hit[g] = prev_q[g] && !sync2_q[g];
                    kwd_pkg::SEL_RISE: hit[g] = !prev_q[g] && sync2_q[g];
                    kwd_pkg::SEL_BOTH: hit[g] = prev_q[g] ^ sync2_q[g];
                    default:           hit[g] = 1'b0;
                endcase
            end
            assign pullup_dyn_o[g] = cfg_q[g].pullup_mode;
        end
    endgenerate

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        cfg_d  = cfg_q;
        mask_d = mask_q;
        for (int i = 0; i < NCH; i++) begin
            if (ch_wr[i]) begin
                cfg_d[i].pullup_mode = wdata_i[kwd_pkg::PULLUP_BIT];
                cfg_d[i].active_sel  =
                    wdata_i[kwd_pkg::SEL_HI:kwd_pkg::SEL_LO];
                cfg_d[i].irq_enable  = wdata_i[kwd_pkg::EN_BIT];
            end
        end
        if (wr_i && addr_i == kwd_pkg::IRQ_MASK_ADDR) begin
            mask_d = wdata_i[NCH-1:0];
        end
        // Set wins over write-one-to-clear
        stat_d = stat_q;
        if (wr_i && addr_i == kwd_pkg::IRQ_STATUS_ADDR) begin
            stat_d = stat_q & ~wdata_i[NCH-1:0];
        end
        for (int i = 0; i < NCH; i++) begin
            if (hit[i] && cfg_q[i].irq_enable) begin
                stat_d[i] = 1'b1;
            end
        end
        rdata_d = 8'h00;
        if (rd_i) begin
            for (int i = 0; i < NCH; i++) begin
                if (addr_i == ch_addr(i)) begin
                    rdata_d[kwd_pkg::PULLUP_BIT] = cfg_q[i].pullup_mode;
                    rdata_d[kwd_pkg::SEL_HI:kwd_pkg::SEL_LO] =
                        cfg_q[i].active_sel;
                    rdata_d[kwd_pkg::EN_BIT] = cfg_q[i].irq_enable;
                    // Bits 3..1 stay zero
                end
            end
            if (addr_i == kwd_pkg::IRQ_STATUS_ADDR) begin
                rdata_d[NCH-1:0] = stat_q;
            end
            if (addr_i == kwd_pkg::IRQ_MASK_ADDR) begin
                rdata_d[NCH-1:0] = mask_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q   <= {NCH{kwd_pkg::CHAN_RESET}};
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q  <= '1;
            stat_q  <= '0;
            mask_q  <= '0;
            rdata_q <= 8'h00;
        end else begin
            cfg_q   <= cfg_d;
            sync1_q <= key_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o   = |(stat_q & mask_q);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------
    a_fall_sets_stat: assert property (
        (cfg_q[0].active_sel == kwd_pkg::SEL_FALL && cfg_q[0].irq_enable
         && prev_q[0] && !sync2_q[0]) |=> stat_q[0])
        else $error("falling edge missed");
    a_rise_sets_stat: assert property (
        (cfg_q[0].active_sel == kwd_pkg::SEL_RISE && cfg_q[0].irq_enable
         && !prev_q[0] && sync2_q[0]) |=> stat_q[0])
        else $error("rising edge missed");
    a_both_sets_stat: assert property (
        (cfg_q[0].active_sel == kwd_pkg::SEL_BOTH && cfg_q[0].irq_enable
         && (prev_q[0] ^ sync2_q[0])) |=> stat_q[0])
        else $error("either edge missed");
    a_low_level: assert property (
        (cfg_q[0].active_sel == kwd_pkg::SEL_LOW && cfg_q[0].irq_enable
         && !sync2_q[0]) |=> stat_q[0])
        else $error("low level missed");
    a_high_level: assert property (
        (cfg_q[0].active_sel == kwd_pkg::SEL_HIGH && cfg_q[0].irq_enable
         && sync2_q[0]) |=> stat_q[0])
        else $error("high level missed");
    // Codes above the both-edges code must stay silent
    a_illegal_sel_quiet: assert property (
        (cfg_q[2].active_sel > kwd_pkg::SEL_BOTH) |-> !hit[2])
        else $error("illegal select detected an event");
    a_disabled_quiet: assert property (
        (!cfg_q[0].irq_enable && !stat_q[0]
         && !(wr_i && addr_i == kwd_pkg::IRQ_STATUS_ADDR)) |=> !stat_q[0])
        else $error("disabled channel set status");

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Only channel registers carry reserved bits; status and mask
    // reads use the low bits
    a_reserved_zero: assert property (
        (rd_i && (addr_i == kwd_pkg::KEY14_CTRL_ADDR
         || addr_i == kwd_pkg::KEY15_CTRL_ADDR
         || addr_i == kwd_pkg::KEY16_CTRL_ADDR))
        |=> (rdata_o[kwd_pkg::SEL_LO-1:kwd_pkg::EN_BIT+1] == '0))
        else $error("reserved bits nonzero");
    a_rdata_idle: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_pullup_follow: assert property (
        ch_wr[0] |=> pullup_dyn_o[0] == $past(wdata_i[kwd_pkg::PULLUP_BIT]))
        else $error("pull-up mode not stored");
    a_sel_store: assert property (
        ch_wr[0] |=> cfg_q[0].active_sel
            == $past(wdata_i[kwd_pkg::SEL_HI:kwd_pkg::SEL_LO]))
        else $error("active select not stored");
    a_enable_store: assert property (
        ch_wr[0] |=> cfg_q[0].irq_enable == $past(wdata_i[kwd_pkg::EN_BIT]))
        else $error("enable not stored");
    a_reset_value: assert property (
        $rose(rst_n_i) |-> cfg_q[0] == kwd_pkg::CHAN_RESET)
        else $error("wrong reset config");
    a_reset_pullup: assert property (
        $rose(rst_n_i) |-> pullup_dyn_o == '0)
        else $error("pull-up mode not static after reset");

    // ------------------------------------------------------------
    // Status and interrupt
    // ------------------------------------------------------------
    // A clear that meets a new event loses, so no event is dropped
    a_status_clear: assert property (
        (wr_i && addr_i == kwd_pkg::IRQ_STATUS_ADDR && wdata_i[0]
         && !(hit[0] && cfg_q[0].irq_enable)) |=> !stat_q[0])
        else $error("status bit not cleared");
    a_status_sticky: assert property (
        (stat_q[0] && !(wr_i && addr_i == kwd_pkg::IRQ_STATUS_ADDR
         && wdata_i[0])) |=> stat_q[0])
        else $error("status bit dropped without a clear");
    a_mask_store: assert property (
        (wr_i && addr_i == kwd_pkg::IRQ_MASK_ADDR)
        |=> mask_q == $past(wdata_i[NCH-1:0]))
        else $error("mask not stored");
    a_irq_level: assert property (
        (wr_i && addr_i == kwd_pkg::IRQ_MASK_ADDR && wdata_i[NCH-1:0] == '0)
        |=> !irq_o)
        else $error("irq raised with all sources masked");

    // ------------------------------------------------------------
    // Cover properties
    // ------------------------------------------------------------
    c_fall_irq: cover property (irq_o && cfg_q[0].active_sel ==
        kwd_pkg::SEL_FALL);
    c_both_edge: cover property (cfg_q[0].active_sel == kwd_pkg::SEL_BOTH
        && stat_q[0]);
    c_clear_stat: cover property (stat_q[0] ##1 !stat_q[0]);
    c_low_irq: cover property (cfg_q[0].active_sel == kwd_pkg::SEL_LOW
        && irq_o);
    c_masked_pending: cover property (stat_q[0] && !irq_o);

endmodule : kwd_key_wakeup

/* File: dv/kwd_key_pins.sv */
`timescale 1ns/1ns
// A released key floats back to its pull-up level, so a press pulls low
module kwd_key_pins (
    input  wire logic       clock_i,
    input  wire logic [2:0] press_i,
    output logic      [2:0] key_o
);
    always_ff @(posedge clock_i) begin
        key_o <= ~press_i;
    end
endmodule : kwd_key_pins

/* File: dv/key_wakeup_input_detect_test.sv */
`timescale 1ns/1ns
module key_wakeup_input_detect_test;
    typedef struct packed {
        logic [2:0] sel;
        logic       en;
        logic       lvl0;
        logic       lvl1;
        logic       irq;
    } kwd_row_t;
    logic        clock_i    = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic [31:0] addr_i     = 32'h0000_0000;
    logic [7:0]  wdata_i    = 8'h00;
    logic        wr_i       = 1'b0;
    logic        rd_i       = 1'b0;
    logic [2:0]  press      = 3'h0;
    logic [7:0]  rdata_o;
    logic [2:0]  key;
    logic [2:0]  pullup_dyn_o;
    logic        irq_o;
    int          err_count  = 0;
    int          num_checks = 0;
    // Pin moves from lvl0 to lvl1 once the channel is configured
    kwd_row_t    rows [11] = '{
        '{kwd_pkg::SEL_LOW,  1'b1, 1'b1, 1'b0, 1'b1},
        '{kwd_pkg::SEL_LOW,  1'b1, 1'b1, 1'b1, 1'b0},
        '{kwd_pkg::SEL_HIGH, 1'b1, 1'b0, 1'b1, 1'b1},
        '{kwd_pkg::SEL_HIGH, 1'b1, 1'b0, 1'b0, 1'b0},
        '{kwd_pkg::SEL_FALL, 1'b1, 1'b1, 1'b0, 1'b1},
        '{kwd_pkg::SEL_FALL, 1'b1, 1'b0, 1'b1, 1'b0},
        '{kwd_pkg::SEL_RISE, 1'b1, 1'b0, 1'b1, 1'b1},
        '{kwd_pkg::SEL_RISE, 1'b1, 1'b1, 1'b0, 1'b0},
        '{kwd_pkg::SEL_FALL, 1'b0, 1'b1, 1'b0, 1'b0},
        '{kwd_pkg::SEL_BOTH, 1'b1, 1'b1, 1'b0, 1'b1},
        '{kwd_pkg::SEL_BOTH, 1'b1, 1'b0, 1'b1, 1'b1}
    };

    always #4 clock_i = ~clock_i;

    kwd_key_pins u_pins (.clock_i(clock_i), .press_i(press), .key_o(key));

    kwd_key_wakeup u_dut (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .addr_i       (addr_i),
        .wdata_i      (wdata_i),
        .wr_i         (wr_i),
        .rd_i         (rd_i),
        .rdata_o      (rdata_o),
        .key_i        (key),
        .pullup_dyn_o (pullup_dyn_o),
        .irq_o        (irq_o)
    );

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1 check(rdata_o, e);
    endtask : rd

    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(kwd_pkg::KEY14_CTRL_ADDR, 8'h20);
        rd(kwd_pkg::KEY15_CTRL_ADDR, 8'h20);
        rd(kwd_pkg::KEY16_CTRL_ADDR, 8'h20);
        check({5'h00, pullup_dyn_o}, 8'h00);
        wr(kwd_pkg::IRQ_MASK_ADDR, 8'h07);
        foreach (rows[i]) begin
            wr(kwd_pkg::KEY14_CTRL_ADDR, 8'h00);
            press <= {2'h0, ~rows[i].lvl0};
            repeat (8) @(posedge clock_i);
            wr(kwd_pkg::IRQ_STATUS_ADDR, 8'h07);
            wr(kwd_pkg::KEY14_CTRL_ADDR,
               {1'b0, rows[i].sel, 3'h0, rows[i].en});
            press <= {2'h0, ~rows[i].lvl1};
            repeat (8) @(posedge clock_i);
            #1 check({7'h00, irq_o}, {7'h00, rows[i].irq});
            rd(kwd_pkg::IRQ_STATUS_ADDR, {7'h00, rows[i].irq});
        end
        // Masked status must keep the line low; a status clear must read back zero
        wr(kwd_pkg::IRQ_MASK_ADDR, 8'h00);
        #1 check({7'h00, irq_o}, 8'h00);
        wr(kwd_pkg::IRQ_STATUS_ADDR, 8'h07);
        wr(kwd_pkg::IRQ_MASK_ADDR, 8'h07);
        rd(kwd_pkg::IRQ_STATUS_ADDR, 8'h00);
        wr(kwd_pkg::KEY16_CTRL_ADDR, 8'hff);
        rd(kwd_pkg::KEY16_CTRL_ADDR, 8'hf1);
        check({5'h00, pullup_dyn_o}, 8'h04);
        wr(kwd_pkg::KEY15_CTRL_ADDR, 8'h7e);
        rd(kwd_pkg::KEY15_CTRL_ADDR, 8'h70);
        check({5'h00, pullup_dyn_o}, 8'h04);
        rd(32'hffff_f3f2, 8'h00);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(kwd_pkg::KEY16_CTRL_ADDR, 8'h20);
        check({5'h00, pullup_dyn_o}, 8'h00);
        print_verdict();
    end
endmodule : key_wakeup_input_detect_test
